// ==== design/gch_pkg.sv ====
package gch_pkg;
  // command codes
  localparam logic [7:0] CMD_AVAIL = 8'h10;
  localparam logic [7:0] CMD_GET_DIR = 8'h11;
  localparam logic [7:0] CMD_GET_POL = 8'h12;
  localparam logic [7:0] CMD_GET_STATE = 8'h13;
  localparam logic [7:0] CMD_SET_DIR = 8'h19;
  localparam logic [7:0] CMD_SET_POL = 8'h1a;
  localparam logic [7:0] CMD_SET_STATE = 8'h1b;
  // frame shape
  localparam int PARAM_BYTES = 8;
  localparam int RESP_BYTES = 4;
  localparam int PIN_COUNT = 32;
  // reset values
  localparam logic [31:0] DIR_RST = 32'h0000_0000;
  localparam logic [31:0] POL_RST = 32'h0000_0000;
  localparam logic [31:0] STATE_RST = 32'h0000_0000;
  localparam logic [31:0] AVAIL_RST = 32'hffff_ffff;
  typedef enum logic [1:0] {
    ST_CMD = 2'b00,
    ST_PARAM = 2'b01,
    ST_RESP = 2'b11
  } gch_state_t;
endpackage : gch_pkg

// ==== design/gch_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module gch_top #(
  parameter logic [31:0] AVAIL_MAP = gch_pkg::AVAIL_RST
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // host bytes in
  input wire logic [7:0] rx_data_i,
  input wire logic rx_valid_i,
  output logic rx_ready_o,
  // host bytes out
  output logic [7:0] tx_data_o,
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  // pins
  input wire logic [31:0] pin_in_i,
  output logic [31:0] dir_o,
  output logic [31:0] pol_o,
  output logic [31:0] pin_level_o
);
  gch_pkg::gch_state_t st_q, st_d;
  logic [7:0] cmd_q, cmd_d;
  logic [3:0] cnt_q, cnt_d;
  logic [63:0] par_q, par_d;
  logic [31:0] dir_q, dir_d, pol_q, pol_d, set_q, set_d;
  logic [31:0] res_q, res_d;
  logic [7:0] tx_q, tx_d;
  logic txv_q, txv_d, rxr_q, rxr_d;
  logic [31:0] pin_s1_q, pin_s2_q;
  logic [31:0] state_now;

  // mask merge shared by all three set commands
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] mask,
                                        input logic [31:0] val);
    merge = (old & ~mask) | (val & mask);
  endfunction : merge

  // pins are external: two flops before anything looks at them
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_s1_q <= 32'h0;
      pin_s2_q <= 32'h0;
    end else begin
      pin_s1_q <= pin_in_i;
      pin_s2_q <= pin_s1_q;
    end
  end

  // outputs report driven state, inputs their level undone by polarity
  assign state_now = (dir_q & set_q) | (~dir_q & (pin_s2_q ^ pol_q));

  always_comb begin
    logic [31:0] wmask;
    logic [31:0] wval;
    wmask = 32'h0;
    wval = 32'h0;
    st_d = st_q;
    cmd_d = cmd_q;
    cnt_d = cnt_q;
    par_d = par_q;
    dir_d = dir_q;
    pol_d = pol_q;
    set_d = set_q;
    res_d = res_q;
    tx_d = tx_q;
    txv_d = txv_q;
    rxr_d = rxr_q;
    case (st_q)
      gch_pkg::ST_CMD: begin
        rxr_d = 1'b1;
        if (rx_valid_i && rxr_q) begin
          cmd_d = rx_data_i;
          cnt_d = 4'h0;
          st_d = gch_pkg::ST_PARAM;
        end
      end
      gch_pkg::ST_PARAM: begin
        if (rx_valid_i && rxr_q) begin
          // low byte first: shift new bytes in from the top
          par_d = {rx_data_i, par_q[63:8]};
          cnt_d = cnt_q + 4'h1;
          if (cnt_q == 4'(gch_pkg::PARAM_BYTES - 1)) begin
            rxr_d = 1'b0;
            wmask = par_d[31:0];
            wval = par_d[63:32];
            case (cmd_q)
              gch_pkg::CMD_SET_DIR: begin
                dir_d = merge(dir_q, wmask, wval);
              end
              gch_pkg::CMD_SET_POL: begin
                pol_d = merge(pol_q, wmask, wval);
              end
              gch_pkg::CMD_SET_STATE: begin
                set_d = merge(set_q, wmask, wval);
              end
              default: ;
            endcase
            // result is taken one cycle later so it sees the updated maps
            st_d = gch_pkg::ST_RESP;
            cnt_d = 4'h0;
            tx_d = cmd_q;
            txv_d = 1'b1;
          end
        end
      end
      gch_pkg::ST_RESP: begin
        if (cnt_q == 4'h0 && !txv_q) begin
          cnt_d = 4'h0;
        end
        if (txv_q && tx_ready_i) begin
          cnt_d = cnt_q + 4'h1;
          if (cnt_q == 4'(gch_pkg::RESP_BYTES)) begin
            txv_d = 1'b0;
            st_d = gch_pkg::ST_CMD;
            rxr_d = 1'b1;
          end else begin
            tx_d = res_q[8*cnt_q[1:0] +: 8];
          end
        end
      end
      default: begin
        st_d = gch_pkg::ST_CMD;
        txv_d = 1'b0;
        rxr_d = 1'b0;
      end
    endcase
    // result map latched while the echo byte waits
    if (st_q == gch_pkg::ST_RESP && cnt_q == 4'h0) begin
      case (cmd_q)
        gch_pkg::CMD_AVAIL: res_d = AVAIL_MAP;
        gch_pkg::CMD_GET_DIR, gch_pkg::CMD_SET_DIR: res_d = dir_q;
        gch_pkg::CMD_GET_POL, gch_pkg::CMD_SET_POL: res_d = pol_q;
        gch_pkg::CMD_GET_STATE, gch_pkg::CMD_SET_STATE: begin
          res_d = state_now;
        end
        default: res_d = 32'h0;
      endcase
      if (txv_q && tx_ready_i) begin
        tx_d = res_d[7:0];
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= gch_pkg::ST_CMD;
      cmd_q <= 8'h0;
      cnt_q <= 4'h0;
      par_q <= 64'h0;
      dir_q <= gch_pkg::DIR_RST;
      pol_q <= gch_pkg::POL_RST;
      set_q <= gch_pkg::STATE_RST;
      res_q <= 32'h0;
      tx_q <= 8'h0;
      txv_q <= 1'b0;
      rxr_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cmd_q <= cmd_d;
      cnt_q <= cnt_d;
      par_q <= par_d;
      dir_q <= dir_d;
      pol_q <= pol_d;
      set_q <= set_d;
      res_q <= res_d;
      tx_q <= tx_d;
      txv_q <= txv_d;
      rxr_q <= rxr_d;
    end
  end

  // pin level: active state flipped for active-low pins
  logic [31:0] lvl_q;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lvl_q <= 32'h0;
    end else begin
      lvl_q <= set_d ^ pol_d;
    end
  end

  assign rx_ready_o = rxr_q;
  assign tx_data_o = tx_q;
  assign tx_valid_o = txv_q;
  assign dir_o = dir_q;
  assign pol_o = pol_q;
  assign pin_level_o = lvl_q;

  // assertions
  sequence s_last_param;
    st_q == gch_pkg::ST_PARAM && rx_valid_i && rxr_q && cnt_q == 4'h7;
  endsequence

  property p_dir_mask;
    @(posedge clk_i) disable iff (!nrst_i)
      (s_last_param and (cmd_q == gch_pkg::CMD_SET_DIR)) |=>
        ((dir_q ^ $past(dir_q)) & ~$past(par_d[31:0])) == 32'h0;
  endproperty
  a_dir_mask: assert property (p_dir_mask)
    else $error("dir unmasked change");

  property p_dir_val;
    @(posedge clk_i) disable iff (!nrst_i)
      (s_last_param and (cmd_q == gch_pkg::CMD_SET_DIR)) |=>
        ((dir_q ^ $past(par_d[63:32])) & $past(par_d[31:0])) == 32'h0;
  endproperty
  a_dir_val: assert property (p_dir_val)
    else $error("dir value wrong");

  property p_pol_val;
    @(posedge clk_i) disable iff (!nrst_i)
      (s_last_param and (cmd_q == gch_pkg::CMD_SET_POL)) |=>
        pol_q == (($past(pol_q) & ~$past(par_d[31:0]))
                  | ($past(par_d[63:32]) & $past(par_d[31:0])));
  endproperty
  a_pol_val: assert property (p_pol_val)
    else $error("pol merge wrong");

  property p_set_val;
    @(posedge clk_i) disable iff (!nrst_i)
      (s_last_param and (cmd_q == gch_pkg::CMD_SET_STATE)) |=>
        set_q == (($past(set_q) & ~$past(par_d[31:0]))
                  | ($past(par_d[63:32]) & $past(par_d[31:0])));
  endproperty
  a_set_val: assert property (p_set_val)
    else $error("state merge wrong");

  property p_echo;
    @(posedge clk_i) disable iff (!nrst_i)
      s_last_param |=> txv_q && tx_q == $past(cmd_q);
  endproperty
  a_echo: assert property (p_echo)
    else $error("echo byte wrong");

  property p_no_rx_in_resp;
    @(posedge clk_i) disable iff (!nrst_i)
      st_q == gch_pkg::ST_RESP |-> !rxr_q;
  endproperty
  a_no_rx_in_resp: assert property (p_no_rx_in_resp)
    else $error("rx open");

  property p_query_keeps;
    @(posedge clk_i) disable iff (!nrst_i)
      (s_last_param and (cmd_q[3] == 1'b0)) |=>
        $stable(dir_q) && $stable(pol_q) && $stable(set_q);
  endproperty
  a_query_keeps: assert property (p_query_keeps)
    else $error("query changed");

  property p_pol_report;
    @(posedge clk_i) disable iff (!nrst_i)
      st_q == gch_pkg::ST_RESP && cnt_q == 4'h0
        && cmd_q == gch_pkg::CMD_GET_POL |=> res_q == $past(pol_q);
  endproperty
  a_pol_report: assert property (p_pol_report)
    else $error("pol report");

  property p_first_lsb;
    @(posedge clk_i) disable iff (!nrst_i)
      st_q == gch_pkg::ST_RESP && cnt_q == 4'h0 && txv_q && tx_ready_i
        |=> tx_q == res_q[7:0];
  endproperty
  a_first_lsb: assert property (p_first_lsb)
    else $error("byte order");

  property p_pol_mask;
    @(posedge clk_i) disable iff (!nrst_i)
      (s_last_param and (cmd_q == gch_pkg::CMD_SET_POL)) |=>
        ((pol_q ^ $past(pol_q)) & ~$past(par_d[31:0])) == 32'h0;
  endproperty
  a_pol_mask: assert property (p_pol_mask)
    else $error("pol unmasked change");

  property p_set_mask;
    @(posedge clk_i) disable iff (!nrst_i)
      (s_last_param and (cmd_q == gch_pkg::CMD_SET_STATE)) |=>
        ((set_q ^ $past(set_q)) & ~$past(par_d[31:0])) == 32'h0;
  endproperty
  a_set_mask: assert property (p_set_mask)
    else $error("state unmasked change");

  property p_state_report;
    @(posedge clk_i) disable iff (!nrst_i)
      st_q == gch_pkg::ST_RESP && cnt_q == 4'h0
        && cmd_q == gch_pkg::CMD_GET_STATE |=> res_q == $past(state_now);
  endproperty
  a_state_report: assert property (p_state_report)
    else $error("state report");

  property p_set_pol_report;
    @(posedge clk_i) disable iff (!nrst_i)
      st_q == gch_pkg::ST_RESP && cnt_q == 4'h0
        && cmd_q == gch_pkg::CMD_SET_POL |=> res_q == $past(pol_q);
  endproperty
  a_set_pol_report: assert property (p_set_pol_report)
    else $error("updated pol report");

  // pin level matches the committed state and polarity in the same cycle
  property p_level;
    @(posedge clk_i) disable iff (!nrst_i)
      1'b1 |-> lvl_q == (set_q ^ pol_q);
  endproperty
  a_level: assert property (p_level)
    else $error("pin level");
endmodule : gch_top
`default_nettype wire

// ==== dv/gch_host.sv ====
`timescale 1ns/1ns
`default_nettype none
module gch_host (
  // clock
  input wire logic clk_i,
  // host byte link
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  // drop answer ready every other cycle
  input wire logic slow_i
);
  logic [7:0] resp_q [5];
  initial begin
    rx_data_o = 8'h00;
    rx_valid_o = 1'b0;
    tx_ready_o = 1'b0;
  end
  task automatic xfer(input logic [7:0] cmd, input logic [31:0] m, v);
    logic [71:0] f;
    int n;
    f = {v, m, cmd};
    for (int i = 0; i < 9; i++) begin
      rx_data_o <= f[8*i +: 8];
      rx_valid_o <= 1'b1;
      do @(posedge clk_i); while (rx_ready_i !== 1'b1);
    end
    rx_valid_o <= 1'b0;
    // released line shows garbage so a stale byte cannot pass
    rx_data_o <= ~f[71:64];
    n = 0;
    while (n < 5) begin
      tx_ready_o <= !(slow_i && tx_ready_o);
      @(posedge clk_i);
      if (tx_valid_i === 1'b1 && tx_ready_o) begin
        resp_q[n] = tx_data_i;
        n++;
      end
    end
    tx_ready_o <= 1'b0;
  endtask : xfer
endmodule : gch_host
`default_nettype wire

// ==== dv/tb_gch_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_gch_top;
  logic clk_i, nrst_i, rx_valid, rx_ready, tx_valid, tx_ready, slow;
  logic [7:0] rx_data, tx_data;
  logic [31:0] pin_in, dir, pol, lvl, m_dir, m_pol, m_st;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  gch_top i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .rx_data_i(rx_data),
    .rx_valid_i(rx_valid), .rx_ready_o(rx_ready), .tx_data_o(tx_data),
    .tx_valid_o(tx_valid), .tx_ready_i(tx_ready), .pin_in_i(pin_in),
    .dir_o(dir), .pol_o(pol), .pin_level_o(lvl));
  gch_host i_host (.clk_i(clk_i), .rx_data_o(rx_data),
    .rx_valid_o(rx_valid), .rx_ready_i(rx_ready), .tx_data_i(tx_data),
    .tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .slow_i(slow));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic chk(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks_done %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  // input pins report synced level seen through polarity
  function automatic logic [31:0] st_exp();
    return (m_st & m_dir) | ((pin_in ^ m_pol) & ~m_dir);
  endfunction : st_exp
  task automatic run(input logic [7:0] cmd, input logic [31:0] m, v, e);
    logic [31:0] r;
    i_host.xfer(cmd, m, v);
    r = {i_host.resp_q[4], i_host.resp_q[3],
         i_host.resp_q[2], i_host.resp_q[1]};
    chk("echo", {24'h0, i_host.resp_q[0]}, {24'h0, cmd});
    chk("result", r, e);
  endtask : run
  task automatic t_dir();
    m_dir = 32'h1234_0000;
    run(gch_pkg::CMD_SET_DIR, 32'hffff_0000, 32'h1234_5678, m_dir);
    chk("dir", dir, m_dir);
    m_dir = 32'h1234_00a5;
    run(gch_pkg::CMD_SET_DIR, 32'h0000_00ff, 32'hffff_ffa5, m_dir);
    run(gch_pkg::CMD_GET_DIR, 32'hffff_ffff, 32'h0, m_dir);
  endtask : t_dir
  task automatic t_pol();
    m_pol = 32'h0000_ff00;
    run(gch_pkg::CMD_SET_POL, 32'h0000_ff00, 32'hffff_ffff, m_pol);
    chk("pol", pol, m_pol);
    m_pol = 32'h0000_00f0;
    run(gch_pkg::CMD_SET_POL, 32'h0000_ffff, 32'h5a5a_00f0, m_pol);
    run(gch_pkg::CMD_GET_POL, 32'hdead_beef, 32'hffff_ffff, m_pol);
  endtask : t_pol
  task automatic t_state();
    pin_in <= 32'h0f0f_f0f0;
    slow <= 1'b1;
    m_st = 32'h0f0f_0f0f;
    // the model must see the new pin levels before it is evaluated
    @(posedge clk_i);
    run(gch_pkg::CMD_SET_STATE, 32'hffff_ffff, m_st, st_exp());
    chk("level", lvl & m_dir, (m_st ^ m_pol) & m_dir);
    m_st = 32'h0d0f_0f0f;
    run(gch_pkg::CMD_SET_STATE, 32'h0200_0000, 32'h0, st_exp());
    run(gch_pkg::CMD_GET_STATE, 32'h0, 32'h0, st_exp());
    run(gch_pkg::CMD_AVAIL, 32'h0, 32'h0, gch_pkg::AVAIL_RST);
    run(8'h7e, 32'hffff_ffff, 32'hffff_ffff, 32'h0);
  endtask : t_state
  initial begin
    nrst_i <= 1'b0;
    pin_in <= 32'h0;
    slow <= 1'b0;
    repeat (12) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    chk("dir_rst", dir, gch_pkg::DIR_RST);
    chk("pol_rst", pol, gch_pkg::POL_RST);
    t_dir();
    t_pol();
    t_state();
    end_of_test();
  end
  // a dead handshake would otherwise hang the run
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      end_of_test();
    end
  end
endmodule : tb_gch_top
`default_nettype wire
